// file: reading_buffer_defines.svh
// register offsets, field positions, reset values and timing counts of the reading buffer
// assumes a 200 MHz system clock and an 8-bit APB byte address
`ifndef READING_BUFFER_DEFINES_SVH
`define READING_BUFFER_DEFINES_SVH

`define RB_OFF_CTRL      8'h00
`define RB_OFF_CAPACITY  8'h04
`define RB_OFF_START     8'h08
`define RB_OFF_END       8'h0C
`define RB_OFF_FIELDS    8'h10
`define RB_OFF_READOUT   8'h14
`define RB_OFF_DATA      8'h18
`define RB_OFF_COUNT     8'h1C

`define RB_CTRL_POLICY_LSB 0
`define RB_CTRL_FEED_BIT   2
`define RB_RO_ACTIVE_BIT   0
`define RB_RO_ERROR_BIT    1

`define RB_INDEX_MIN     12'h001
`define RB_INDEX_MAX     12'h9C4
`define RB_CAP_MIN       12'h002
`define RB_CAP_MAX       12'h9C4
`define RB_CAP_RESET     12'h064

`define RB_FLD_READING   0
`define RB_FLD_SOURCE    1
`define RB_FLD_UNIT      2
`define RB_FLD_MODE      3
`define RB_FLD_DATE      4
`define RB_FLD_TIME      5
`define RB_FLD_ABS_STAMP 6
`define RB_FLD_REL       7
`define RB_FLD_REL_STAMP 8
`define RB_FLD_INDEX     9
`define RB_FIELDS_DEFAULT 10'h087
`define RB_SLOT_LAST     4'hA
`define RB_SLOT_NONE     4'hF

`define RB_CLK_PERIOD_NS 5
`define RB_TICK_NS       1000000
`define RB_TICK_CYCLES   (`RB_TICK_NS / `RB_CLK_PERIOD_NS)
`define RB_DAY_HOURS     24
`define RB_DAY_TICKS     (`RB_DAY_HOURS * 3600 * 1000)

`endif

// file: reading_buffer_pkg.sv
// types shared by the reading buffer and its measurement source
// assumes reading_buffer_defines.svh is compiled alongside
package reading_buffer_pkg;

  typedef enum logic [1:0] {
    fill_once_policy = 2'h0,
    continuous_policy = 2'h1,
    no_fill_policy = 2'h2
  } fill_policy_e;

  typedef enum logic {
    pre_math_feed = 1'h0,
    post_math_feed = 1'h1
  } feed_source_e;

  typedef enum logic [1:0] {
    output_off_state = 2'h0,
    constant_current_state = 2'h1,
    constant_voltage_state = 2'h2
  } output_state_e;

  typedef struct packed {
    logic [31:0] reading;
    logic [31:0] source;
    logic reading_amps;
    logic source_amps;
    output_state_e mode;
    logic [31:0] date;
    logic [31:0] time_of_day;
    logic [26:0] elapsed_ms;
  } record_s;

  typedef struct packed {
    logic valid;
    logic [31:0] value;
    logic [31:0] math_value;
    logic math_on;
    logic [31:0] source;
    logic reading_amps;
    logic source_amps;
    output_state_e mode;
    logic [31:0] date;
    logic [31:0] time_of_day;
  } measurement_s;

endpackage

// file: elapsed_time_counter.sv
// millisecond counter of time since the first stored record
// assumes restart is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
`include "reading_buffer_defines.svh"
module elapsed_time_counter #(
  parameter int TICK_CYCLES = `RB_TICK_CYCLES,
  parameter int DAY_TICKS = `RB_DAY_TICKS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic restart,
  output logic [26:0] elapsed_ms
);

  typedef struct packed {
    logic [17:0] div;
    logic [26:0] ms;
  } timer_state_s;

  timer_state_s st_q;
  timer_state_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (restart)
    begin
      st_d.div = 18'h00000;
      st_d.ms = 27'h0000000;
    end
    else if (st_q.div == 18'(TICK_CYCLES - 1))
    begin
      st_d.div = 18'h00000;
      // restart each day
      if (st_q.ms == 27'(DAY_TICKS - 1))
        st_d.ms = 27'h0000000;
      else
        st_d.ms = st_q.ms + 27'h0000001;
    end
    else
    begin
      st_d.div = st_q.div + 18'h00001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign elapsed_ms = st_q.ms;

endmodule

// file: reading_buffer_store.sv
// reading storage buffer with fill policies and selected-range readout over APB
// assumes measurement inputs are on sys_clk; apb master per AMBA APB
//
// Functional notes
// - range readout start index lies between 1 and 2500
// - range readout end index lies between 1 and 2500
// - index 1 addresses the oldest stored record
// - empty field list returns reading, source, unit and relative time
// - feed source picks pre-math or post-math readings
// - pre-math feed never stores a math result
// - fill-once stops at capacity and discards further readings
// - continuous wraps to first location, newest replaces oldest
// - no_fill_policy-fill policy stores nothing
// - capacity programmable 2 to 2500 and readable back
// - relative time counts from first record, restarts every 24 hours
// - date, time and stamp come from the real-time clock
// - output state field reports constant current, constant voltage or off
// - index field reports the record's buffer position
// - unit field gives units of reading, source and timestamp
// - readings append until capacity or storage stops
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "reading_buffer_defines.svh"
module reading_buffer_store #(
  parameter int DEPTH = 2500,
  parameter int TICK_CYCLES = `RB_TICK_CYCLES,
  parameter int DAY_TICKS = `RB_DAY_TICKS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire reading_buffer_pkg::measurement_s meas
);

  typedef struct packed {
    reading_buffer_pkg::record_s [DEPTH-1:0] mem;
    reading_buffer_pkg::fill_policy_e policy;
    reading_buffer_pkg::feed_source_e feed;
    logic [11:0] capacity;
    logic [11:0] count;
    logic [11:0] wr_ptr;
    logic [11:0] start_idx;
    logic [11:0] end_idx;
    logic [9:0] fields;
    logic ro_active;
    logic ro_error;
    logic [11:0] ro_idx;
    logic [11:0] ro_end;
    logic [9:0] ro_mask;
    logic [3:0] ro_slot;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } store_state_s;

  store_state_s st_q;
  store_state_s st_d;
  logic [26:0] elapsed_ms;
  logic first_store;

  // which field a readout word slot belongs to; the absolute stamp spans two slots
  function automatic logic [3:0] slot_field(input logic [3:0] slot);
    case (slot)
      4'h0: slot_field = 4'(`RB_FLD_READING);
      4'h1: slot_field = 4'(`RB_FLD_SOURCE);
      4'h2: slot_field = 4'(`RB_FLD_UNIT);
      4'h3: slot_field = 4'(`RB_FLD_MODE);
      4'h4: slot_field = 4'(`RB_FLD_DATE);
      4'h5: slot_field = 4'(`RB_FLD_TIME);
      4'h6: slot_field = 4'(`RB_FLD_ABS_STAMP);
      4'h7: slot_field = 4'(`RB_FLD_ABS_STAMP);
      4'h8: slot_field = 4'(`RB_FLD_REL);
      4'h9: slot_field = 4'(`RB_FLD_REL_STAMP);
      default: slot_field = 4'(`RB_FLD_INDEX);
    endcase
  endfunction

  // first enabled slot at or after from
  function automatic logic [3:0] next_slot(input logic [9:0] mask, input logic [3:0] from);
    logic [3:0] found;
    found = `RB_SLOT_NONE;
    for (int i = 10; i >= 0; i--)
    begin
      if (4'(i) >= from && mask[slot_field(4'(i))])
        found = 4'(i);
    end
    next_slot = found;
  endfunction

  // index 1 is the oldest record; once full the oldest sits at the write pointer
  function automatic logic [11:0] phys_addr(input logic [11:0] idx, input logic [11:0] cnt,
                                            input logic [11:0] cap, input logic [11:0] wr);
    logic [12:0] sum;
    sum = {1'b0, (cnt == cap) ? wr : 12'h000} + {1'b0, idx} - 13'h0001;
    if (sum >= {1'b0, cap})
      sum = sum - {1'b0, cap};
    phys_addr = sum[11:0];
  endfunction

  function automatic logic [31:0] slot_word(input reading_buffer_pkg::record_s rec, input logic [3:0] slot,
                                            input logic [11:0] idx);
    case (slot)
      4'h0: slot_word = rec.reading;
      4'h1: slot_word = rec.source;
      // bit0 reading, bit1 source: 0 volts, 1 amperes; bit2 always 1, timestamp in milliseconds
      4'h2: slot_word = {29'h00000000, 1'b1, rec.source_amps, rec.reading_amps};
      4'h3: slot_word = {30'h00000000, rec.mode};
      4'h4: slot_word = rec.date;
      4'h5: slot_word = rec.time_of_day;
      4'h6: slot_word = rec.date;
      4'h7: slot_word = rec.time_of_day;
      4'h8: slot_word = {5'h00, rec.elapsed_ms};
      4'h9: slot_word = {5'h00, rec.elapsed_ms};
      default: slot_word = {20'h00000, idx};
    endcase
  endfunction

  elapsed_time_counter #(
    .TICK_CYCLES(TICK_CYCLES),
    .DAY_TICKS(DAY_TICKS)
  ) u_elapsed (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(first_store),
    .elapsed_ms(elapsed_ms)
  );

  logic store_en;
  logic [31:0] feed_value;
  logic [11:0] rd_phys;
  logic [31:0] cur_word;
  logic addr_ok;
  logic [9:0] eff_mask;
  logic [3:0] adv_slot;

  always_comb
  begin
    // pre-math feed ignores the math stage entirely
    if (st_q.feed == reading_buffer_pkg::post_math_feed && meas.math_on)
      feed_value = meas.math_value;
    else
      feed_value = meas.value;
    case (st_q.policy)
      reading_buffer_pkg::fill_once_policy: store_en = meas.valid && (st_q.count < st_q.capacity);
      reading_buffer_pkg::continuous_policy: store_en = meas.valid;
      default: store_en = 1'b0;
    endcase
    first_store = store_en && (st_q.count == 12'h000);
    rd_phys = phys_addr(st_q.ro_idx, st_q.count, st_q.capacity, st_q.wr_ptr);
    cur_word = st_q.ro_active ? slot_word(st_q.mem[rd_phys], st_q.ro_slot, st_q.ro_idx) : 32'h00000000;
    eff_mask = (st_q.fields == 10'h000) ? `RB_FIELDS_DEFAULT : st_q.fields;
    adv_slot = (st_q.ro_slot == `RB_SLOT_LAST) ? `RB_SLOT_NONE : next_slot(st_q.ro_mask, st_q.ro_slot + 4'h1);
    case (paddr)
      `RB_OFF_CTRL, `RB_OFF_CAPACITY, `RB_OFF_START, `RB_OFF_END,
      `RB_OFF_FIELDS, `RB_OFF_READOUT, `RB_OFF_DATA, `RB_OFF_COUNT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;

    // storage path
    if (store_en)
    begin
      st_d.mem[st_q.wr_ptr].reading = feed_value;
      st_d.mem[st_q.wr_ptr].source = meas.source;
      st_d.mem[st_q.wr_ptr].reading_amps = meas.reading_amps;
      st_d.mem[st_q.wr_ptr].source_amps = meas.source_amps;
      st_d.mem[st_q.wr_ptr].mode = meas.mode;
      st_d.mem[st_q.wr_ptr].date = meas.date;
      st_d.mem[st_q.wr_ptr].time_of_day = meas.time_of_day;
      st_d.mem[st_q.wr_ptr].elapsed_ms = first_store ? 27'h0000000 : elapsed_ms;
      if (st_q.wr_ptr + 12'h001 >= st_q.capacity)
        st_d.wr_ptr = 12'h000;
      else
        st_d.wr_ptr = st_q.wr_ptr + 12'h001;
      if (st_q.count < st_q.capacity)
        st_d.count = st_q.count + 12'h001;
    end

    // apb: one wait state, data and error registered
    if (psel && penable && !st_q.pready)
    begin
      st_d.pready = 1'b1;
      st_d.pslverr = !addr_ok;
      case (paddr)
        `RB_OFF_CTRL: st_d.prdata = {29'h00000000, st_q.feed, st_q.policy};
        `RB_OFF_CAPACITY: st_d.prdata = {20'h00000, st_q.capacity};
        `RB_OFF_START: st_d.prdata = {20'h00000, st_q.start_idx};
        `RB_OFF_END: st_d.prdata = {20'h00000, st_q.end_idx};
        `RB_OFF_FIELDS: st_d.prdata = {22'h000000, st_q.fields};
        `RB_OFF_READOUT: st_d.prdata = {30'h00000000, st_q.ro_error, st_q.ro_active};
        `RB_OFF_DATA: st_d.prdata = cur_word;
        `RB_OFF_COUNT: st_d.prdata = {20'h00000, st_q.count};
        default: st_d.prdata = 32'h00000000;
      endcase
    end

    // commit at the edge where pready is sampled high
    if (psel && penable && st_q.pready)
    begin
      if (pwrite)
      begin
        case (paddr)
          `RB_OFF_CTRL:
          begin
            case (pwdata[`RB_CTRL_POLICY_LSB +: 2])
              2'h0: st_d.policy = reading_buffer_pkg::fill_once_policy;
              2'h1: st_d.policy = reading_buffer_pkg::continuous_policy;
              2'h2: st_d.policy = reading_buffer_pkg::no_fill_policy;
              default: st_d.policy = st_q.policy;
            endcase
            st_d.feed = reading_buffer_pkg::feed_source_e'(pwdata[`RB_CTRL_FEED_BIT]);
          end
          `RB_OFF_CAPACITY:
          begin
            // resizing empties the buffer and aborts readout
            if (pwdata[31:12] != 20'h00000 || pwdata[11:0] > `RB_CAP_MAX)
              st_d.capacity = `RB_CAP_MAX;
            else if (pwdata[11:0] < `RB_CAP_MIN)
              st_d.capacity = `RB_CAP_MIN;
            else
              st_d.capacity = pwdata[11:0];
            st_d.count = 12'h000;
            st_d.wr_ptr = 12'h000;
            st_d.ro_active = 1'b0;
          end
          `RB_OFF_START: st_d.start_idx = pwdata[11:0];
          `RB_OFF_END: st_d.end_idx = pwdata[11:0];
          `RB_OFF_FIELDS: st_d.fields = pwdata[9:0];
          `RB_OFF_READOUT:
          begin
            if (pwdata[`RB_RO_ACTIVE_BIT])
            begin
              if (st_q.start_idx >= `RB_INDEX_MIN && st_q.start_idx <= `RB_INDEX_MAX &&
                  st_q.end_idx >= st_q.start_idx && st_q.end_idx <= `RB_INDEX_MAX &&
                  st_q.end_idx <= st_q.count)
              begin
                st_d.ro_active = 1'b1;
                st_d.ro_error = 1'b0;
                st_d.ro_idx = st_q.start_idx;
                st_d.ro_end = st_q.end_idx;
                st_d.ro_mask = eff_mask;
                st_d.ro_slot = next_slot(eff_mask, 4'h0);
              end
              else
              begin
                st_d.ro_active = 1'b0;
                st_d.ro_error = 1'b1;
              end
            end
            else
            begin
              st_d.ro_active = 1'b0;
            end
          end
          default: st_d.ro_error = st_q.ro_error;
        endcase
      end
      else if (paddr == `RB_OFF_DATA && st_q.ro_active)
      begin
        // each data read pops one word: fields of a record, then the next index
        if (adv_slot != `RB_SLOT_NONE)
          st_d.ro_slot = adv_slot;
        else if (st_q.ro_idx == st_q.ro_end)
          st_d.ro_active = 1'b0;
        else
        begin
          st_d.ro_idx = st_q.ro_idx + 12'h001;
          st_d.ro_slot = next_slot(st_q.ro_mask, 4'h0);
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
      st_q.policy <= reading_buffer_pkg::continuous_policy;
      st_q.feed <= reading_buffer_pkg::pre_math_feed;
      st_q.capacity <= `RB_CAP_RESET;
      st_q.start_idx <= `RB_INDEX_MIN;
      st_q.end_idx <= `RB_INDEX_MIN;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;

endmodule

// file: reading_buffer_store_assertions.sv
// concurrent checks on the reading buffer apb port
// assumes reading_buffer_defines.svh and reading_buffer_pkg are compiled first
`timescale 1ns/1ps
`include "reading_buffer_defines.svh"
module reading_buffer_store_assertions #(
  parameter int DEPTH = 2500
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire reading_buffer_pkg::measurement_s meas
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence first_access;
    psel && penable && !$past(penable);
  endsequence
  sequence read_done(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  a_ready_timing: assert property (first_access |=> pready)
    else $error("no pready one cycle after first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_unmapped_err: assert property (pready && (paddr > `RB_OFF_COUNT || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (pready && paddr <= `RB_OFF_COUNT && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_cap_range: assert property (read_done(`RB_OFF_CAPACITY) |-> prdata >= 32'h2 && prdata <= 32'h9C4)
    else $error("capacity outside 2 to 2500");
  a_count_bound: assert property (read_done(`RB_OFF_COUNT) |-> prdata <= DEPTH)
    else $error("stored count above depth");
  a_ctrl_fields: assert property (read_done(`RB_OFF_CTRL) |-> prdata[31:3] == 29'h0 && prdata[1:0] != 2'h3)
    else $error("control readback holds bad bits");
  a_status_bits: assert property (read_done(`RB_OFF_READOUT) |-> prdata[31:2] == 30'h0)
    else $error("readout status holds bad bits");
endmodule
bind reading_buffer_store reading_buffer_store_assertions #(.DEPTH(DEPTH)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas));

// file: measurement_source.sv
// measurement path stand-in offering numbered readings
// assumes go is a one-cycle request on sys_clk
`timescale 1ns/1ps
module measurement_source (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic math_on,
  output reading_buffer_pkg::measurement_s meas
);
  logic [15:0] num_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      num_q <= 16'h0000;
      meas <= '0;
    end
    else if (go)
    begin
      num_q <= num_q + 16'h0001;
      meas.valid <= 1'b1;
      meas.value <= {16'h0000, num_q} + 32'h0000_1000;
      meas.math_value <= {16'h0000, num_q} + 32'h0000_2000;
      meas.math_on <= math_on;
      meas.source <= {16'h0000, num_q} + 32'h0000_3000;
      meas.reading_amps <= num_q[0];
      meas.source_amps <= num_q[1];
      meas.mode <= reading_buffer_pkg::output_state_e'(2'(num_q % 16'h0003));
      meas.date <= {16'h0000, num_q} + 32'h0000_4000;
      meas.time_of_day <= {16'h0000, num_q} + 32'h0000_5000;
    end
    else
    begin
      // scrambled so that no stale field looks valid
      meas <= ~meas;
      meas.valid <= 1'b0;
    end
  end
endmodule

// file: tb.sv
// self-checking bench for the reading buffer over apb
// assumes the design, package, defines and source model are compiled first
`timescale 1ns/1ps
`include "reading_buffer_defines.svh"
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic go = 1'b0;
  logic math_on = 1'b0;
  reading_buffer_pkg::measurement_s meas;
  int num_errors = 0;
  int total_checks = 0;
  int fired = 0;
  int base;
  logic [31:0] r;
  logic e;
  always #2.5 sys_clk = ~sys_clk;
  reading_buffer_store #(.DEPTH(8), .TICK_CYCLES(4), .DAY_TICKS(20)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas));
  measurement_source src (.sys_clk(sys_clk), .sys_rst(sys_rst), .go(go), .math_on(math_on), .meas(meas));
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50)
      num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 32'h0, x, y);
    chk(x, exp);
  endtask
  task automatic fire(input int k);
    repeat (k)
    begin
      @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      fired++;
    end
  endtask
  function automatic logic [31:0] word(input int b, input int n, input int idx, input logic post);
    case (b)
      0: return (post ? 32'h0000_2000 : 32'h0000_1000) + 32'(n);
      1: return 32'h0000_3000 + 32'(n);
      2: return {29'h0, 1'b1, 1'(n >> 1), 1'(n)};
      3: return 32'(n % 3);
      4: return 32'h0000_4000 + 32'(n);
      5: return 32'h0000_5000 + 32'(n);
      9: return 32'(idx);
      default: return 32'h0;
    endcase
  endfunction
  task automatic readout(input int s, input int en, input logic [9:0] mask, input int b0, input logic post);
    logic [9:0] m;
    m = (mask == 10'h000) ? `RB_FIELDS_DEFAULT : mask;
    wr(`RB_OFF_START, 32'(s));
    wr(`RB_OFF_END, 32'(en));
    wr(`RB_OFF_FIELDS, {22'h0, mask});
    wr(`RB_OFF_READOUT, 32'h1);
    for (int i = s; i <= en; i++)
      for (int b = 0; b < 10; b++)
        if (m[b])
          rc(`RB_OFF_DATA, word(b, b0 + i - 1, i, post));
    rc(`RB_OFF_READOUT, 32'h0);
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rc(`RB_OFF_CTRL, 32'h1);
    rc(`RB_OFF_CAPACITY, 32'h64);
    rc(`RB_OFF_COUNT, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wr(`RB_OFF_CAPACITY, 32'h1);
    rc(`RB_OFF_CAPACITY, 32'h2);
    wr(`RB_OFF_CAPACITY, 32'hBB8);
    rc(`RB_OFF_CAPACITY, 32'h9C4);
    wr(`RB_OFF_CTRL, 32'h2);
    wr(`RB_OFF_CAPACITY, 32'h2);
    fire(3);
    rc(`RB_OFF_COUNT, 32'h0);
    wr(`RB_OFF_CTRL, 32'h1);
    base = fired;
    fire(3);
    rc(`RB_OFF_COUNT, 32'h2);
    readout(1, 2, 10'h201, base + 1, 1'b0);
    wr(`RB_OFF_CTRL, 32'h0);
    wr(`RB_OFF_CAPACITY, 32'h5);
    base = fired;
    fire(7);
    rc(`RB_OFF_COUNT, 32'h5);
    readout(1, 5, 10'h201, base, 1'b0);
    wr(`RB_OFF_CTRL, 32'h1);
    wr(`RB_OFF_CAPACITY, 32'h4);
    math_on <= 1'b1;
    base = fired;
    fire(6);
    rc(`RB_OFF_COUNT, 32'h4);
    readout(1, 4, 10'h00B, base + 2, 1'b0);
    readout(2, 3, 10'h001, base + 2, 1'b0);
    wr(`RB_OFF_CTRL, 32'h5);
    rc(`RB_OFF_CTRL, 32'h5);
    wr(`RB_OFF_CAPACITY, 32'h3);
    base = fired;
    fire(1);
    readout(1, 1, 10'h000, base, 1'b1);
    readout(1, 1, 10'h034, base, 1'b1);
    wr(`RB_OFF_END, 32'h2);
    wr(`RB_OFF_READOUT, 32'h1);
    rc(`RB_OFF_READOUT, 32'h2);
    wr(`RB_OFF_START, 32'h0);
    wr(`RB_OFF_END, 32'h1);
    wr(`RB_OFF_READOUT, 32'h1);
    rc(`RB_OFF_READOUT, 32'h2);
    conclude();
  end
endmodule
